// *** rtl/can_buf_pkg.sv ***
// Constants, field layouts and carrier types for the CAN buffer control block.
// Assumes a 10 MHz system clock and a 32-bit APB register bus.
package can_buf_pkg;
	localparam int NUM_BUF = 8;
	localparam int NUM_PAIR = 4;
	localparam int WORDS_PER_BUF = 8;
	// APB byte offsets
	localparam logic [7:0] PAIR_CTRL_BASE_OFS = 8'h00;
	localparam logic [7:0] RX_FULL_OFS = 8'h10;
	localparam logic [7:0] RX_OVF_OFS = 8'h14;
	localparam logic [7:0] BUF_AREA_OFS = 8'h18;
	localparam logic [15:0] PAIR_CTRL_RESET = 16'h0000;
	// Buffer control byte fields
	localparam int DIR_BIT = 7;
	localparam int ABT_BIT = 6;
	localparam int LARB_BIT = 5;
	localparam int ERR_BIT = 4;
	localparam int REQ_BIT = 3;
	localparam int RTREN_BIT = 2;
	localparam int PRI_LSB = 0;
	// Message word indices and fields
	localparam logic [2:0] WORD_SID = 3'h0;
	localparam logic [2:0] WORD_EID_HI = 3'h1;
	localparam logic [2:0] WORD_EID_LO = 3'h2;
	localparam logic [2:0] WORD_DATA0 = 3'h3;
	localparam logic [2:0] WORD_HIT = 3'h7;
	localparam int SID_LSB = 2;
	localparam int SRR_BIT = 1;
	localparam int IDE_BIT = 0;
	localparam int RTR_BIT = 9;
	localparam int HIT_LSB = 8;
	typedef struct packed {
		logic [10:0] sid;
		logic srr;
		logic ide;
		logic [17:0] eid;
		logic rtr;
		logic [3:0] dlc;
		logic [63:0] data;
		logic [4:0] filter_hit_code;
		logic [2:0] buf_idx;
	} rx_msg_t;
	typedef struct packed {
		logic ok;
		logic lost;
		logic err;
	} tx_result_t;
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ram_wr_t;
endpackage

// *** rtl/rx_buffer_writer.sv ***
// Sequences one received message into eight words of buffer RAM.
// Assumes the caller only starts it when idle and the buffer is writable.
`timescale 1ns/10ps
`default_nettype none
module rx_buffer_writer
	import can_buf_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire rx_msg_t msg,
	input wire logic [15:0] area_base,
	output ram_wr_t ram_q,
	output logic done_q,
	output logic busy_q
);
	typedef enum logic [1:0] {W_IDLE = 2'b00, W_WRITE = 2'b01, W_DONE = 2'b11} wr_state_t;
	wr_state_t state_q;
	logic [2:0] word_q;
	rx_msg_t msg_q;
	logic [15:0] word_val;

	// Pack the message into the buffer word layout
	always_comb begin
		case (word_q)
			WORD_SID: word_val = {3'h0, msg_q.sid, msg_q.srr, msg_q.ide};
			WORD_EID_HI: word_val = {4'h0, msg_q.eid[17:6]};
			WORD_EID_LO: word_val = {msg_q.eid[5:0], msg_q.rtr, 1'b0, 3'h0, 1'b0, msg_q.dlc};
			3'h3: word_val = msg_q.data[15:0];
			3'h4: word_val = msg_q.data[31:16];
			3'h5: word_val = msg_q.data[47:32];
			3'h6: word_val = msg_q.data[63:48];
			default: word_val = {3'h0, msg_q.filter_hit_code, 8'h00};
		endcase
	end

	// One word per cycle; done only after the last word lands
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= W_IDLE;
			word_q <= 3'h0;
			msg_q <= '0;
			ram_q <= '0;
			done_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			ram_q.we <= 1'b0;
			case (state_q)
				W_IDLE: begin
					if (start) begin
						msg_q <= msg;
						word_q <= 3'h0;
						busy_q <= 1'b1;
						state_q <= W_WRITE;
					end
				end
				W_WRITE: begin
					ram_q.we <= 1'b1;
					ram_q.addr <= area_base + {10'h000, msg_q.buf_idx, word_q};
					ram_q.wdata <= word_val;
					word_q <= word_q + 3'h1;
					if (word_q == WORD_HIT) begin
						state_q <= W_DONE;
					end
				end
				W_DONE: begin
					done_q <= 1'b1;
					busy_q <= 1'b0;
					state_q <= W_IDLE;
				end
				default: state_q <= W_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** rtl/can_buffer_control.sv ***
// CAN buffer pair control registers, transmit arbitration and receive store.
// Assumes a protocol core that sends frames, reports results and delivers
// accepted receive messages; message contents live in external RAM.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Each pair register: high byte odd buffer, low byte even buffer.
// - Direction bit 1 makes a transmit buffer, 0 a receive buffer.
// - Aborted flag set when message aborted, zero on success.
// - Lost-arbitration flag set when arbitration was lost.
// - Transmit-error flag set when a bus error hits sending.
// - Setting send request clears the three result flags.
// - Software sets send request; hardware clears it on success.
// - Writing zero to a set send request aborts the message.
// - Auto-remote enable sets send request on received remote request.
// - Priority 11 highest down to 00 lowest.
// - Message words are kept in external RAM, not registers.
// - Word 0: identifier bits 12-2, SRR bit 1, IDE bit 0.
// - IDE one sends an extended identifier, zero standard.
// - Standard frames: SRR one means remote request.
// - Word 1: extended identifier 17-6 in bits 11-0.
// - Word 2: identifier 5-0, RTR, reserved bits, length code.
// - Extended frames: RTR one means remote; ignored for standard.
// - Words 3-6 carry data bytes, even byte low.
// - Word 7 bits 12-8 get the hitting filter number.
// - Filter hit written only for receive buffers.
// - Full flag set on store; software clears by writing zero.
// - Overflow flag set when storing into a full buffer.
module can_buffer_control
	import can_buf_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_end,
	input wire tx_result_t tx_result,
	input wire logic [15:0] tx_word0,
	input wire logic [15:0] tx_word2,
	input wire logic rx_remote,
	input wire logic [2:0] rx_remote_idx,
	input wire logic rx_valid,
	input wire rx_msg_t rx_msg,
	output logic rx_ready,
	output logic tx_start,
	output logic [2:0] tx_idx,
	output logic tx_abort,
	output logic tx_ext,
	output logic tx_remote,
	output ram_wr_t ram_wr
);
	// ***************************************************************
	// Register state
	// ***************************************************************
	logic [NUM_BUF-1:0] dir_q, abt_q, larb_q, err_q, req_q, rtren_q;
	logic [1:0] pri_q [NUM_BUF];
	logic [NUM_BUF-1:0] full_q, ovf_q;
	logic [15:0] area_q;
	logic busy_q;
	logic [2:0] cur_q;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic tx_start_q, tx_abort_q, tx_ext_q, tx_remote_q, rx_ready_q;
	logic [2:0] tx_idx_q;

	logic acc, wr_en, rd_en, map_ok;
	logic [2:0] pair_sel;
	logic pair_hit;
	logic [7:0] wbyte [NUM_BUF];
	logic [NUM_BUF-1:0] bwr, req_set_sw, req_clr_sw;
	logic [NUM_BUF-1:0] ev_ok, ev_lost, ev_err, ev_remote, ev_store, ev_ovf;
	logic rx_take, rx_drop_dir;
	logic wr_done, wr_busy;
	logic [2:0] rx_msg_q_idx;
	ram_wr_t wr_port;

	// ***************************************************************
	// APB decode
	// ***************************************************************
	// Access phase completes one cycle after it starts; writes commit only at the ready edge
	assign acc = psel && penable && !pready_q;
	assign pair_sel = paddr[4:2];
	assign pair_hit = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'b00);
	assign map_ok = pair_hit || paddr == RX_FULL_OFS || paddr == RX_OVF_OFS || paddr == BUF_AREA_OFS;
	assign wr_en = psel && penable && pready_q && pwrite && map_ok;
	assign rd_en = acc && !pwrite && map_ok;

	// ***************************************************************
	// Per-buffer events
	// ***************************************************************
	generate
		for (genvar b = 0; b < NUM_BUF; b++) begin : g_evt
			// Even buffer in low byte, odd buffer in high byte
			assign wbyte[b] = (b % 2 == 1) ? pwdata[15:8] : pwdata[7:0];
			assign bwr[b] = wr_en && pair_hit && (pair_sel == 3'(b / 2));
			assign req_set_sw[b] = bwr[b] && wbyte[b][REQ_BIT];
			assign req_clr_sw[b] = bwr[b] && !wbyte[b][REQ_BIT] && req_q[b];
			assign ev_ok[b] = tx_end && busy_q && cur_q == 3'(b) && tx_result.ok;
			assign ev_lost[b] = tx_end && busy_q && cur_q == 3'(b) && tx_result.lost;
			assign ev_err[b] = tx_end && busy_q && cur_q == 3'(b) && tx_result.err;
			assign ev_remote[b] = rx_remote && rx_remote_idx == 3'(b) && rtren_q[b];
			assign ev_store[b] = wr_done && rx_msg_q_idx == 3'(b);
			assign ev_ovf[b] = rx_take && rx_msg.buf_idx == 3'(b) && full_q[b];
		end
	endgenerate

	// ***************************************************************
	// Buffer control bits
	// ***************************************************************
	generate
		for (genvar b = 0; b < NUM_BUF; b++) begin : g_ctl
			// Software fields
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					dir_q[b] <= PAIR_CTRL_RESET[DIR_BIT];
					rtren_q[b] <= PAIR_CTRL_RESET[RTREN_BIT];
					pri_q[b] <= PAIR_CTRL_RESET[PRI_LSB +: 2];
				end else if (bwr[b]) begin
					dir_q[b] <= wbyte[b][DIR_BIT];
					rtren_q[b] <= wbyte[b][RTREN_BIT];
					pri_q[b] <= wbyte[b][PRI_LSB +: 2];
				end
			end
			// Send request: hardware sets win over clears
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					req_q[b] <= PAIR_CTRL_RESET[REQ_BIT];
				end else if (req_set_sw[b] || ev_remote[b]) begin
					req_q[b] <= 1'b1;
				end else if (ev_ok[b] || req_clr_sw[b]) begin
					req_q[b] <= 1'b0;
				end
			end
			// Result flags; a new event wins over the clear by request set
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					abt_q[b] <= PAIR_CTRL_RESET[ABT_BIT];
					larb_q[b] <= PAIR_CTRL_RESET[LARB_BIT];
					err_q[b] <= PAIR_CTRL_RESET[ERR_BIT];
				end else begin
					if (req_clr_sw[b]) begin
						abt_q[b] <= 1'b1;
					end else if (req_set_sw[b] || ev_remote[b] || ev_ok[b]) begin
						abt_q[b] <= 1'b0;
					end
					if (ev_lost[b]) begin
						larb_q[b] <= 1'b1;
					end else if (req_set_sw[b] || ev_remote[b]) begin
						larb_q[b] <= 1'b0;
					end
					if (ev_err[b]) begin
						err_q[b] <= 1'b1;
					end else if (req_set_sw[b] || ev_remote[b]) begin
						err_q[b] <= 1'b0;
					end
				end
			end
			// Full and overflow: hardware set wins over software clear
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					full_q[b] <= 1'b0;
					ovf_q[b] <= 1'b0;
				end else begin
					if (ev_store[b]) begin
						full_q[b] <= 1'b1;
					end else if (wr_en && paddr == RX_FULL_OFS && !pwdata[b]) begin
						full_q[b] <= 1'b0;
					end
					if (ev_ovf[b]) begin
						ovf_q[b] <= 1'b1;
					end else if (wr_en && paddr == RX_OVF_OFS && !pwdata[b]) begin
						ovf_q[b] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Buffer area base, a RAM word address chosen by software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			area_q <= 16'h0000;
		end else if (wr_en && paddr == BUF_AREA_OFS) begin
			area_q <= pwdata[15:0];
		end
	end

	// ***************************************************************
	// Transmit arbitration
	// ***************************************************************
	logic found;
	logic [2:0] win;
	logic [1:0] win_pri;
	// Strict greater-than keeps the lower buffer number on ties
	always_comb begin
		found = 1'b0;
		win = 3'h0;
		win_pri = 2'b00;
		for (int b = 0; b < NUM_BUF; b++) begin
			if (req_q[b] && dir_q[b] && (!found || pri_q[b] > win_pri)) begin
				found = 1'b1;
				win = 3'(b);
				win_pri = pri_q[b];
			end
		end
	end

	// One frame in flight; held until the core reports its end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			cur_q <= 3'h0;
			tx_start_q <= 1'b0;
			tx_idx_q <= 3'h0;
			tx_abort_q <= 1'b0;
		end else begin
			tx_start_q <= 1'b0;
			tx_abort_q <= busy_q && req_clr_sw[cur_q] && !tx_end;
			if (busy_q && tx_end) begin
				busy_q <= 1'b0;
			end else if (!busy_q && found) begin
				busy_q <= 1'b1;
				cur_q <= win;
				tx_start_q <= 1'b1;
				tx_idx_q <= win;
			end
		end
	end

	// Frame kind from header words fetched by the core
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_ext_q <= 1'b0;
			tx_remote_q <= 1'b0;
		end else begin
			tx_ext_q <= tx_word0[IDE_BIT];
			// Standard uses SRR, extended uses RTR
			tx_remote_q <= tx_word0[IDE_BIT] ? tx_word2[RTR_BIT] : tx_word0[SRR_BIT];
		end
	end

	// ***************************************************************
	// Receive store
	// ***************************************************************
	// Transmit buffers never get written, so no filter hit lands there
	assign rx_drop_dir = dir_q[rx_msg.buf_idx];
	assign rx_take = rx_valid && rx_ready_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_ready_q <= 1'b0;
			rx_msg_q_idx <= 3'h0;
		end else begin
			rx_ready_q <= !wr_busy && !rx_take;
			if (rx_take) begin
				rx_msg_q_idx <= rx_msg.buf_idx;
			end
		end
	end

	rx_buffer_writer u_writer (
		.clk(clk),
		.rst_n(rst_n),
		.start(rx_take && !rx_drop_dir && !full_q[rx_msg.buf_idx]),
		.msg(rx_msg),
		.area_base(area_q),
		.ram_q(wr_port),
		.done_q(wr_done),
		.busy_q(wr_busy)
	);

	// ***************************************************************
	// APB read and response
	// ***************************************************************
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		if (pair_hit) begin
			for (int b = 0; b < NUM_BUF; b++) begin
				if (pair_sel == 3'(b / 2)) begin
					rd_val[(b % 2) * 8 +: 8] = {dir_q[b], abt_q[b], larb_q[b], err_q[b],
						req_q[b], rtren_q[b], pri_q[b]};
				end
			end
		end else if (paddr == RX_FULL_OFS) begin
			rd_val[NUM_BUF-1:0] = full_q;
		end else if (paddr == RX_OVF_OFS) begin
			rd_val[NUM_BUF-1:0] = ovf_q;
		end else if (paddr == BUF_AREA_OFS) begin
			rd_val[15:0] = area_q;
		end
	end

	// Ready one cycle into the access phase; unmapped answers with an error
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc && !map_ok;
			prdata_q <= rd_en ? rd_val : 32'h0000_0000;
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign rx_ready = rx_ready_q;
	assign tx_start = tx_start_q;
	assign tx_idx = tx_idx_q;
	assign tx_abort = tx_abort_q;
	assign tx_ext = tx_ext_q;
	assign tx_remote = tx_remote_q;
	assign ram_wr = wr_port;
endmodule
`default_nettype wire

// *** bench/can_buf_checker_assertions.sv ***
// Port checker for the CAN buffer control block.
// Assumes bind to can_buffer_control and a RAM area base that is a multiple of 8.
`timescale 1ns/10ps
`default_nettype none
module can_buf_checker
	import can_buf_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] tx_word0,
	input wire logic [15:0] tx_word2,
	input wire logic tx_end,
	input wire logic tx_start,
	input wire logic tx_abort,
	input wire logic tx_ext,
	input wire logic tx_remote,
	input wire ram_wr_t ram_wr
);
	// ****
	// Frame tracking
	// ****
	logic busy_q;
	// Open from start until end or abort
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			busy_q <= 1'h0;
		else if (tx_start)
			busy_q <= 1'h1;
		else if (tx_end || tx_abort)
			busy_q <= 1'h0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ****
	// Properties
	// ****
	one_frame_a: assert property (tx_start |-> !busy_q)
		else $error("start while a frame is open");
	ext_sel_a: assert property ($past(rst_n) |-> tx_ext == $past(tx_word0[IDE_BIT]))
		else $error("extended flag wrong");
	remote_sel_a: assert property ($past(rst_n) |-> tx_remote ==
		($past(tx_word0[IDE_BIT]) ? $past(tx_word2[RTR_BIT]) : $past(tx_word0[SRR_BIT])))
		else $error("remote flag wrong");
	burst_len_a: assert property ($rose(ram_wr.we) |-> ram_wr.we [*8] ##1 !ram_wr.we)
		else $error("store burst not eight words");
	first_word_a: assert property ($rose(ram_wr.we) |-> ram_wr.addr[2:0] == WORD_SID)
		else $error("store does not begin at word 0");
	word_step_a: assert property (ram_wr.we && $past(ram_wr.we) |->
		ram_wr.addr == $past(ram_wr.addr) + 16'h0001)
		else $error("store words out of order");
	sid_pad_a: assert property (ram_wr.we && ram_wr.addr[2:0] == WORD_SID |-> ram_wr.wdata[15:13] == 3'h0)
		else $error("word 0 pad not zero");
	eid_pad_a: assert property (ram_wr.we && ram_wr.addr[2:0] == WORD_EID_HI |-> ram_wr.wdata[15:12] == 4'h0)
		else $error("word 1 pad not zero");
	resv_zero_a: assert property (ram_wr.we && ram_wr.addr[2:0] == WORD_EID_LO |-> ram_wr.wdata[8:4] == 5'h00)
		else $error("word 2 reserved bits not zero");
	hit_pad_a: assert property (ram_wr.we && ram_wr.addr[2:0] == WORD_HIT |->
		ram_wr.wdata[15:13] == 3'h0 && ram_wr.wdata[7:0] == 8'h00)
		else $error("word 7 pad not zero");
endmodule
bind can_buffer_control can_buf_checker u_chk (.clk(clk), .rst_n(rst_n), .tx_word0(tx_word0),
	.tx_word2(tx_word2), .tx_end(tx_end), .tx_start(tx_start), .tx_abort(tx_abort),
	.tx_ext(tx_ext), .tx_remote(tx_remote), .ram_wr(ram_wr));
`default_nettype wire

// *** bench/can_node_model.sv ***
// Behavioural bus side: each started frame ends after a fixed time.
// Assumes the bench commands the result; an abort cancels the frame.
`timescale 1ns/10ps
`default_nettype none
module can_node_model
	import can_buf_pkg::*;
#(
	parameter int FRAME = 30
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tx_start,
	input wire logic tx_abort,
	input wire tx_result_t res_cmd,
	output logic tx_end,
	output tx_result_t tx_result
);
	// ****
	// Frame timer
	// ****
	int cnt;
	logic cut_q;
	// Result valid only with the end pulse, garbage elsewhere
	// An abort still closes the frame, with no result bits, so the block frees up
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			cut_q <= 1'h0;
			tx_end <= 1'h0;
			tx_result <= 3'h0;
		end else begin
			tx_end <= (cnt == 1);
			tx_result <= (cnt != 1) ? ~res_cmd : (cut_q ? 3'h0 : res_cmd);
			if (tx_start) begin
				cnt <= FRAME;
				cut_q <= 1'h0;
			end else if (tx_abort && cnt > 1) begin
				cnt <= 1;
				cut_q <= 1'h1;
			end else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for can_buffer_control over APB.
// Assumes the node model on the transmit side; the bench plays the receiver.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import can_buf_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, last_err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic tx_end, rx_remote, rx_valid, rx_ready, tx_start, tx_abort, tx_ext, tx_remote;
	logic [15:0] tx_word0, tx_word2;
	logic [2:0] rx_remote_idx, tx_idx;
	tx_result_t tx_result, res_cmd;
	rx_msg_t rx_msg, m;
	ram_wr_t ram_wr;
	logic [15:0] mem [0:255];
	logic [15:0] e [0:7];
	logic [2:0] ord [0:3] = '{3'h1, 3'h2, 3'h3, 3'h0};
	logic [2:0] starts [$];
	int fail_count, samples_checked, nwr, nabt, i, n;
	can_buffer_control u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_end(tx_end), .tx_result(tx_result), .tx_word0(tx_word0),
		.tx_word2(tx_word2), .rx_remote(rx_remote), .rx_remote_idx(rx_remote_idx),
		.rx_valid(rx_valid), .rx_msg(rx_msg), .rx_ready(rx_ready), .tx_start(tx_start),
		.tx_idx(tx_idx), .tx_abort(tx_abort), .tx_ext(tx_ext), .tx_remote(tx_remote), .ram_wr(ram_wr));
	can_node_model u_node (.clk(clk), .rst_n(rst_n), .tx_start(tx_start), .tx_abort(tx_abort),
		.res_cmd(res_cmd), .tx_end(tx_end), .tx_result(tx_result));
	// 10 MHz clock
	always #50 clk = ~clk;
	// Log starts, aborts and RAM words
	always @(posedge clk) begin
		if (tx_start)
			starts.push_back(tx_idx);
		if (tx_abort)
			nabt++;
		if (ram_wr.we) begin
			mem[ram_wr.addr[7:0]] = ram_wr.wdata;
			nwr++;
		end
	end
	// ****
	// Tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	// Holds the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		apb(1'h0, a, 32'h0, q);
		check(q, x);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'h1, a, d, q);
	endtask
	task automatic wait_end();
		do @(posedge clk); while (tx_end !== 1'h1);
	endtask
	// Message lines go to garbage once taken
	task automatic rx_send();
		rx_valid <= 1'h1;
		do @(posedge clk); while (rx_ready !== 1'h1);
		rx_valid <= 1'h0;
		rx_msg <= ~rx_msg;
		repeat (14) @(posedge clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ****
	// Tests
	// ****
	initial begin
		{clk, rst_n, psel, penable, pwrite, paddr, pwdata, rx_remote, rx_remote_idx, rx_valid} = '0;
		{rx_msg, fail_count, samples_checked, nwr, nabt} = '0;
		tx_word0 = 16'h0003;
		tx_word2 = 16'h0200;
		res_cmd = 3'h4;
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		for (i = 0; i < 4; i++)
			rd(8'(4 * i), 32'h0);
		rd(8'hFC, 32'h0);
		check({31'h0, last_err}, 32'h1);
		wr(BUF_AREA_OFS, 32'h0100);
		wr(PAIR_CTRL_BASE_OFS, 32'h8988);
		wr(8'h04, 32'h8B8B);
		while (starts.size() < 4)
			@(posedge clk);
		wait_end();
		@(posedge clk);
		for (i = 0; i < 4; i++)
			check(starts[i], ord[i]);
		rd(8'h00, 32'h8180);
		rd(8'h04, 32'h8383);
		$display("test priority done");
		tx_word0 <= 16'h0001;
		for (i = 0; i < 2; i++) begin
			res_cmd <= i ? 3'h1 : 3'h2;
			wr(8'h08, 32'h0088);
			wait_end();
			rd(8'h08, i ? 32'h0098 : 32'h00A8);
			wr(8'h08, 32'h0080);
			rd(8'h08, i ? 32'h00D0 : 32'h00E0);
		end
		check(nabt, 2);
		$display("test results done");
		res_cmd <= 3'h4;
		tx_word0 <= 16'h0002;
		for (i = 0; i < 2; i++) begin
			wr(8'h08, i ? 32'h8080 : 32'h8480);
			n = starts.size();
			rx_remote <= 1'h1;
			rx_remote_idx <= 3'h5;
			@(posedge clk);
			rx_remote <= 1'h0;
			repeat (40) @(posedge clk);
			check(starts.size() - n, i ? 0 : 1);
			rd(8'h08, i ? 32'h80D0 : 32'h84D0);
		end
		$display("test remote done");
		m = {11'h5A3, 1'h1, 1'h1, 18'h2B3C7, 1'h1, 4'h8, 64'h0123456789ABCDEF, 5'h15, 3'h6};
		e[0] = {3'h0, m.sid, m.srr, m.ide};
		e[1] = {4'h0, m.eid[17:6]};
		e[2] = {m.eid[5:0], m.rtr, 5'h00, m.dlc};
		for (i = 0; i < 4; i++)
			e[3 + i] = m.data[16 * i +: 16];
		e[7] = {3'h0, m.filter_hit_code, 8'h00};
		rx_msg <= m;
		rx_send();
		for (i = 0; i < 8; i++)
			check(mem[8'h30 + i], e[i]);
		rd(RX_FULL_OFS, 32'h40);
		rx_msg <= m;
		rx_send();
		rd(RX_OVF_OFS, 32'h40);
		check(nwr, 8);
		wr(RX_FULL_OFS, 32'h0);
		rd(RX_FULL_OFS, 32'h0);
		m.buf_idx = 3'h4;
		rx_msg <= m;
		rx_send();
		check(nwr, 8);
		$display("test receive done");
		give_verdict();
	end
	// Watchdog far beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("ERROR %0t watchdog expired", $time);
		give_verdict();
	end
endmodule
`default_nettype wire
